// File: core/pfs_regs.vh
/*
 Register offsets, field positions, reset values and keys of the pin function
 selection and readback block. Assumes inclusion by the design file only.
*/
`ifndef PFS_REGS_VH
`define PFS_REGS_VH
`define PFS_ADDR_PBS_LO 4'h0
`define PFS_ADDR_PBS_HI 4'h1
`define PFS_ADDR_PCS_LO 4'h2
`define PFS_ADDR_PCS_HI 4'h3
`define PFS_ADDR_PDS 4'h4
`define PFS_ADDR_IN_SRC 4'h5
`define PFS_ADDR_CAP_SRC 4'h6
`define PFS_ADDR_IRQ_SRC 4'h7
`define PFS_ADDR_KEY 4'h8
`define PFS_RST_VAL 8'h00
`define PFS_KEY_VALUE 8'hca
`define PFS_PCS_HI_MASK 8'h0f
`define PFS_PDS_MASK 8'hf0
`define PFS_IN_SRC_MASK 8'h61
`define PFS_CAP_SRC_MASK 8'h01
`define PFS_IRQ_SRC_MASK 8'h03
`define PFS_BIT_PT0_SRC 5
`define PFS_BIT_PT1_SRC 6
`define PFS_BIT_ST_SRC 0
`define PFS_BIT_CAP_SRC 0
`define PFS_BIT_IRQ1_SRC 1
`define PFS_BIT_IRQ0_SRC 0
`define PFS_CODE_ALT 2'b10
`define PFS_CODE_TOP 2'b11
`endif

// File: core/pfs_mux.v
/*
 Pin function multiplexer for ports B, C and D with input source selection
 and a keyed readback mode for self test of port reads and analog paths.
 Assumes synchronous pin inputs, one clock and a single-cycle register port.
*/
// Implementation choices: the strobed register port and the register addresses.
// Contract
// - PB0 codes 00/01 GPIO, 10 analog channel 0, 11 reference input.
// - PB3 codes 00-10 GPIO with timer1 clock, 11 analog channel 3.
// - PB2 codes 00-10 GPIO with timer0 clock, 11 analog channel 2.
// - PB1 codes 00-10 GPIO with standard timer clock, 11 analog 1.
// - PB7 GPIO or external reset, 11 analog 7; reset control wins.
// - PB6 codes 00-10 GPIO with capture input, 11 analog channel 6.
// - PB5 GPIO with irq one, 10 inverted standard timer, 11 analog 5.
// - PB4 GPIO with irq zero, 10 inverted timer0 output, 11 analog 4.
// - PC3 GPIO, 10 serial clock, 11 LCD segment 2.
// - PC2 GPIO, 10 serial data out or UART transmit, 11 segment 1.
// - PC1 GPIO, 10 serial data in/I2C/UART, 11 LCD segment 0.
// - PC0 codes 00-10 GPIO with capture input, 11 serial chip select.
// - PC5 and PC4 GPIO for 00-10, crystal pins for 11.
// - PD3 and PD2 GPIO for 00-10, inverted and true timer1 for 11.
// - Timer0 clock from PA4 when 0, PB2 when 1.
// - Timer1 clock from PD0 when 0, PB3 when 1.
// - Standard timer clock from PA5 when 0, PB1 when 1.
// - Capture input from PB6 when 0, PC0 when 1.
// - Irq one from PA1 or PB5, irq zero from PA3 or PB4.
// - Readback enabled only while key holds 11001010; key resets to zero.
// - Readback on: reads give pin levels; off: inputs pin, outputs latch.
// - Readback off: analog, reset and non-serial outputs read 0.
// - Analog path closes if selected and analog; readback forces it.
`include "pfs_regs.vh"
module pfs_mux (
    MCLK,
    SRST,
    ADDR,
    WDATA,
    WR,
    RD,
    RDATA,
    RESET_PIN_CONTROL_RES_EN,
    PA_IN,
    PB_IN,
    PC_IN,
    PD_IN,
    PB_LATCH,
    PC_LATCH,
    PD_LATCH,
    PB_DIR,
    PC_DIR,
    PD_DIR,
    PB_OUT,
    PC_OUT,
    PD_OUT,
    PB_OE_N,
    PC_OE_N,
    PD_OE_N,
    PB_READ,
    PC_READ,
    PD_READ,
    ST_OUT,
    PT0_OUT,
    PT1_OUT,
    SCK_OUT,
    SCK_OE,
    SDO_OUT,
    SDO_OE,
    SDA_OUT,
    SDA_OE,
    SCS_OUT,
    SCS_OE,
    SEG_OUT,
    ADC_CH_SEL,
    ST_CLK_IN,
    PT0_CLK_IN,
    PT1_CLK_IN,
    ST_CAP_IN,
    IRQ0_IN,
    IRQ1_IN,
    EXT_RST_IN,
    SER_CLK_IN,
    SER_DATA_IN,
    SER_CS_IN,
    AN_PATH_ON,
    VREF_PIN_ON,
    XTAL_ON,
    READBACK_EN
);
    input wire MCLK;
    input wire SRST;
    input wire [3:0] ADDR;
    input wire [7:0] WDATA;
    input wire WR;
    input wire RD;
    output reg [7:0] RDATA;
    input wire RESET_PIN_CONTROL_RES_EN;
    input wire [7:0] PA_IN;
    input wire [7:0] PB_IN;
    input wire [7:0] PC_IN;
    input wire [7:0] PD_IN;
    input wire [7:0] PB_LATCH;
    input wire [7:0] PC_LATCH;
    input wire [7:0] PD_LATCH;
    input wire [7:0] PB_DIR;
    input wire [7:0] PC_DIR;
    input wire [7:0] PD_DIR;
    output reg [7:0] PB_OUT;
    output reg [7:0] PC_OUT;
    output reg [7:0] PD_OUT;
    output reg [7:0] PB_OE_N;
    output reg [7:0] PC_OE_N;
    output reg [7:0] PD_OE_N;
    output reg [7:0] PB_READ;
    output reg [7:0] PC_READ;
    output reg [7:0] PD_READ;
    input wire ST_OUT;
    input wire PT0_OUT;
    input wire PT1_OUT;
    input wire SCK_OUT;
    input wire SCK_OE;
    input wire SDO_OUT;
    input wire SDO_OE;
    input wire SDA_OUT;
    input wire SDA_OE;
    input wire SCS_OUT;
    input wire SCS_OE;
    input wire [2:0] SEG_OUT;
    input wire [2:0] ADC_CH_SEL;
    output reg ST_CLK_IN;
    output reg PT0_CLK_IN;
    output reg PT1_CLK_IN;
    output reg ST_CAP_IN;
    output reg IRQ0_IN;
    output reg IRQ1_IN;
    output reg EXT_RST_IN;
    output reg SER_CLK_IN;
    output reg SER_DATA_IN;
    output reg SER_CS_IN;
    output reg [7:0] AN_PATH_ON;
    output reg VREF_PIN_ON;
    output reg XTAL_ON;
    output reg READBACK_EN;

    reg [7:0] pbs_lo_q;
    reg [7:0] pbs_hi_q;
    reg [7:0] pcs_lo_q;
    reg [7:0] pcs_hi_q;
    reg [7:0] pds_q;
    reg [7:0] in_src_q;
    reg [7:0] cap_src_q;
    reg [7:0] irq_src_q;
    reg [7:0] key_q;
    reg [7:0] rdata_d;

    // Two-bit selector code of pin n within a byte of four fields
    function [1:0] fcode;
        input [7:0] r;
        input [1:0] n;
        begin
            fcode = r[2*n+:2];
        end
    endfunction

    // Readback disabled: plain GPIO reads pin or latch by direction
    function gpio_rd;
        input pin;
        input latch;
        input dir_in;
        begin
            gpio_rd = dir_in ? pin : latch;
        end
    endfunction

    wire rb_on = (key_q == `PFS_KEY_VALUE);

    // Per-pin masks: plain GPIO, serial (reads pin), analog, alternate drive
    reg [7:0] pb_gpio;
    reg [7:0] pc_gpio;
    reg [7:0] pd_gpio;
    reg [7:0] pc_ser;
    reg [7:0] pb_an;
    reg [7:0] pb_alt_o;
    reg [7:0] pb_alt_v;
    reg [7:0] pc_alt_o;
    reg [7:0] pc_alt_oen;
    reg [7:0] pd_alt_o;
    reg [7:0] pd_alt_v;
    reg pb7_res;
    integer i;
    integer j;

    always @* begin
        pb_gpio = 8'hff;
        pc_gpio = 8'hff;
        pd_gpio = 8'hff;
        pc_ser = 8'h00;
        pb_an = 8'h00;
        pb_alt_o = 8'h00;
        pb_alt_v = 8'h00;
        pc_alt_o = 8'h00;
        pc_alt_oen = 8'hff;
        pd_alt_o = 8'h00;
        pd_alt_v = 8'h00;
        // Analog channels 0..7 sit on PB0..PB7 at code 11, except PB0 at 10
        for (j = 1; j < 8; j = j + 1) begin
            if (fcode(j < 4 ? pbs_lo_q : pbs_hi_q, j[1:0]) == `PFS_CODE_TOP) begin
                pb_an[j] = 1'b1;
                pb_gpio[j] = 1'b0;
            end
        end
        if (fcode(pbs_lo_q, 2'd0) == `PFS_CODE_ALT) begin
            pb_an[0] = 1'b1;
            pb_gpio[0] = 1'b0;
        end
        if (fcode(pbs_lo_q, 2'd0) == `PFS_CODE_TOP) begin
            pb_gpio[0] = 1'b0;
        end
        if (fcode(pbs_hi_q, 2'd1) == `PFS_CODE_ALT) begin
            pb_gpio[5] = 1'b0;
            pb_alt_v[5] = 1'b1;
            pb_alt_o[5] = ~ST_OUT;
        end
        if (fcode(pbs_hi_q, 2'd0) == `PFS_CODE_ALT) begin
            pb_gpio[4] = 1'b0;
            pb_alt_v[4] = 1'b1;
            pb_alt_o[4] = ~PT0_OUT;
        end
        // Reset control outranks the selector on PB7
        pb7_res = RESET_PIN_CONTROL_RES_EN;
        if (pb7_res) begin
            pb_gpio[7] = 1'b0;
            pb_an[7] = 1'b0;
        end
        if (fcode(pcs_lo_q, 2'd3) == `PFS_CODE_ALT) begin
            pc_gpio[3] = 1'b0;
            pc_ser[3] = 1'b1;
            pc_alt_o[3] = SCK_OUT;
            pc_alt_oen[3] = ~SCK_OE;
        end
        if (fcode(pcs_lo_q, 2'd2) == `PFS_CODE_ALT) begin
            pc_gpio[2] = 1'b0;
            pc_ser[2] = 1'b1;
            pc_alt_o[2] = SDO_OUT;
            pc_alt_oen[2] = ~SDO_OE;
        end
        if (fcode(pcs_lo_q, 2'd1) == `PFS_CODE_ALT) begin
            pc_gpio[1] = 1'b0;
            pc_ser[1] = 1'b1;
            pc_alt_o[1] = SDA_OUT;
            pc_alt_oen[1] = ~SDA_OE;
        end
        for (j = 1; j < 4; j = j + 1) begin
            if (fcode(pcs_lo_q, j[1:0]) == `PFS_CODE_TOP) begin
                pc_gpio[j] = 1'b0;
                pc_alt_o[j] = SEG_OUT[j-1];
                pc_alt_oen[j] = 1'b0;
            end
        end
        if (fcode(pcs_lo_q, 2'd0) == `PFS_CODE_TOP) begin
            pc_gpio[0] = 1'b0;
            pc_ser[0] = 1'b1;
            pc_alt_o[0] = SCS_OUT;
            pc_alt_oen[0] = ~SCS_OE;
        end
        // Crystal pins are analog: no digital drive, read zero while readback is off
        if (fcode(pcs_hi_q, 2'd1) == `PFS_CODE_TOP) begin
            pc_gpio[5] = 1'b0;
        end
        if (fcode(pcs_hi_q, 2'd0) == `PFS_CODE_TOP) begin
            pc_gpio[4] = 1'b0;
        end
        if (fcode(pds_q, 2'd3) == `PFS_CODE_TOP) begin
            pd_gpio[3] = 1'b0;
            pd_alt_v[3] = 1'b1;
            pd_alt_o[3] = ~PT1_OUT;
        end
        if (fcode(pds_q, 2'd2) == `PFS_CODE_TOP) begin
            pd_gpio[2] = 1'b0;
            pd_alt_v[2] = 1'b1;
            pd_alt_o[2] = PT1_OUT;
        end
    end

    always @* begin
        rdata_d = 8'h00;
        case (ADDR)
            `PFS_ADDR_PBS_LO: rdata_d = pbs_lo_q;
            `PFS_ADDR_PBS_HI: rdata_d = pbs_hi_q;
            `PFS_ADDR_PCS_LO: rdata_d = pcs_lo_q;
            `PFS_ADDR_PCS_HI: rdata_d = pcs_hi_q;
            `PFS_ADDR_PDS: rdata_d = pds_q;
            `PFS_ADDR_IN_SRC: rdata_d = in_src_q;
            `PFS_ADDR_CAP_SRC: rdata_d = cap_src_q;
            `PFS_ADDR_IRQ_SRC: rdata_d = irq_src_q;
            `PFS_ADDR_KEY: rdata_d = key_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // Registers: unimplemented bits are masked so they read zero
    always @(posedge MCLK) begin
        if (SRST) begin
            pbs_lo_q <= `PFS_RST_VAL;
            pbs_hi_q <= `PFS_RST_VAL;
            pcs_lo_q <= `PFS_RST_VAL;
            pcs_hi_q <= `PFS_RST_VAL;
            pds_q <= `PFS_RST_VAL;
            in_src_q <= `PFS_RST_VAL;
            cap_src_q <= `PFS_RST_VAL;
            irq_src_q <= `PFS_RST_VAL;
            key_q <= `PFS_RST_VAL;
            RDATA <= 8'h00;
        end else begin
            if (WR) begin
                case (ADDR)
                    `PFS_ADDR_PBS_LO: pbs_lo_q <= WDATA;
                    `PFS_ADDR_PBS_HI: pbs_hi_q <= WDATA;
                    `PFS_ADDR_PCS_LO: pcs_lo_q <= WDATA;
                    `PFS_ADDR_PCS_HI: pcs_hi_q <= WDATA & `PFS_PCS_HI_MASK;
                    `PFS_ADDR_PDS: pds_q <= WDATA & `PFS_PDS_MASK;
                    `PFS_ADDR_IN_SRC: in_src_q <= WDATA & `PFS_IN_SRC_MASK;
                    `PFS_ADDR_CAP_SRC: cap_src_q <= WDATA & `PFS_CAP_SRC_MASK;
                    `PFS_ADDR_IRQ_SRC: irq_src_q <= WDATA & `PFS_IRQ_SRC_MASK;
                    `PFS_ADDR_KEY: key_q <= WDATA;
                    default: ;
                endcase
            end
            RDATA <= RD ? rdata_d : 8'h00;
        end
    end

    // Routing outputs are registered, so they follow register state by one cycle
    always @(posedge MCLK) begin
        if (SRST) begin
            PB_OUT <= 8'h00;
            PC_OUT <= 8'h00;
            PD_OUT <= 8'h00;
            PB_OE_N <= 8'hff;
            PC_OE_N <= 8'hff;
            PD_OE_N <= 8'hff;
            PB_READ <= 8'h00;
            PC_READ <= 8'h00;
            PD_READ <= 8'h00;
            ST_CLK_IN <= 1'b0;
            PT0_CLK_IN <= 1'b0;
            PT1_CLK_IN <= 1'b0;
            ST_CAP_IN <= 1'b0;
            IRQ0_IN <= 1'b0;
            IRQ1_IN <= 1'b0;
            EXT_RST_IN <= 1'b1;
            SER_CLK_IN <= 1'b0;
            SER_DATA_IN <= 1'b0;
            SER_CS_IN <= 1'b1;
            AN_PATH_ON <= 8'h00;
            VREF_PIN_ON <= 1'b0;
            XTAL_ON <= 1'b0;
            READBACK_EN <= 1'b0;
        end else begin
            for (i = 0; i < 8; i = i + 1) begin
                PB_OUT[i] <= pb_gpio[i] ? PB_LATCH[i] : pb_alt_o[i];
                PB_OE_N[i] <= pb_gpio[i] ? PB_DIR[i] : ~pb_alt_v[i];
                PC_OUT[i] <= pc_gpio[i] ? PC_LATCH[i] : pc_alt_o[i];
                PC_OE_N[i] <= pc_gpio[i] ? PC_DIR[i] : pc_alt_oen[i];
                PD_OUT[i] <= pd_gpio[i] ? PD_LATCH[i] : pd_alt_o[i];
                PD_OE_N[i] <= pd_gpio[i] ? PD_DIR[i] : ~pd_alt_v[i];
                // Readback returns the pin itself; otherwise function decides
                PB_READ[i] <= rb_on ? PB_IN[i] :
                    (pb_gpio[i] ? gpio_rd(PB_IN[i], PB_LATCH[i], PB_DIR[i]) : 1'b0);
                PC_READ[i] <= rb_on ? PC_IN[i] :
                    (pc_gpio[i] ? gpio_rd(PC_IN[i], PC_LATCH[i], PC_DIR[i]) :
                    (pc_ser[i] ? PC_IN[i] : 1'b0));
                PD_READ[i] <= rb_on ? PD_IN[i] :
                    (pd_gpio[i] ? gpio_rd(PD_IN[i], PD_LATCH[i], PD_DIR[i]) : 1'b0);
                // Forcing the path lets the pin's own driver test the converter
                AN_PATH_ON[i] <= (ADC_CH_SEL == i[2:0]) && (pb_an[i] || rb_on);
            end
            // Shared digital inputs read raw pins; direction is software's job
            PT0_CLK_IN <= in_src_q[`PFS_BIT_PT0_SRC] ? PB_IN[2] : PA_IN[4];
            PT1_CLK_IN <= in_src_q[`PFS_BIT_PT1_SRC] ? PB_IN[3] : PD_IN[0];
            ST_CLK_IN <= in_src_q[`PFS_BIT_ST_SRC] ? PB_IN[1] : PA_IN[5];
            ST_CAP_IN <= cap_src_q[`PFS_BIT_CAP_SRC] ? PC_IN[0] : PB_IN[6];
            IRQ1_IN <= irq_src_q[`PFS_BIT_IRQ1_SRC] ? PB_IN[5] : PA_IN[1];
            IRQ0_IN <= irq_src_q[`PFS_BIT_IRQ0_SRC] ? PB_IN[4] : PA_IN[3];
            EXT_RST_IN <= pb7_res ? PB_IN[7] : 1'b1;
            SER_CLK_IN <= pc_ser[3] ? PC_IN[3] : 1'b0;
            SER_DATA_IN <= pc_ser[1] ? PC_IN[1] : 1'b0;
            SER_CS_IN <= pc_ser[0] ? PC_IN[0] : 1'b1;
            VREF_PIN_ON <= (fcode(pbs_lo_q, 2'd0) == `PFS_CODE_TOP);
            XTAL_ON <= (pcs_hi_q[3:0] == 4'hf);
            READBACK_EN <= rb_on;
        end
    end
endmodule

// File: verif/pfs_mux_sva.sv
/* Checker for the pin function mux: shadow registers and routing relations.
   Assumes binding to pfs_mux and a register port that never stalls. */
module pfs_mux_sva (
    input logic MCLK,
    input logic SRST,
    input logic [3:0] ADDR,
    input logic [7:0] WDATA,
    input logic WR,
    input logic RD,
    input logic [7:0] RDATA,
    input logic RESET_PIN_CONTROL_RES_EN,
    input logic [7:0] PA_IN,
    input logic [7:0] PB_IN,
    input logic [7:0] PC_IN,
    input logic [7:0] PB_LATCH,
    input logic [7:0] PB_DIR,
    input logic [7:0] PB_READ,
    input logic [2:0] ADC_CH_SEL,
    input logic ST_CAP_IN,
    input logic IRQ0_IN,
    input logic EXT_RST_IN,
    input logic [7:0] AN_PATH_ON,
    input logic READBACK_EN
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh [0:8];
    wire [7:0] key_sh = sh[8];
    wire rb = key_sh == 8'hca;
    // Capture, irq and plain-read relations are checked only while the five pin function selector registers (sh[0] to sh[4]) are zero
    wire fz = (sh[0] | sh[1] | sh[2] | sh[3] | sh[4]) == 8'h00;
    wire [3:0] gp_x = (PB_DIR[3:0] & PB_IN[3:0]) | (~PB_DIR[3:0] & PB_LATCH[3:0]);
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            for (int i = 0; i < 9; i++) begin
                sh[i] <= 8'h00;
            end
        end else if (WR && ADDR < 4'h9) begin
            sh[ADDR] <= WDATA;
        end
    end
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SRST);
    property p_route(logic o, logic x);
        !$past(SRST) && $past(fz) |-> o == $past(x);
    endproperty
    AST_KEY_ON: assert property (WR && ADDR == 4'h8 && WDATA == 8'hca |-> ##2 READBACK_EN)
        else $error("readback not enabled by key");
    AST_KEY_OFF: assert property (WR && ADDR == 4'h8 && WDATA != 8'hca |-> ##2 !READBACK_EN)
        else $error("readback enabled by wrong key");
    AST_RD_KEY: assert property (RD && ADDR == 4'h8 |=> RDATA == $past(key_sh))
        else $error("key readback wrong");
    AST_CAP: assert property (p_route(ST_CAP_IN, sh[6][0] ? PC_IN[0] : PB_IN[6]))
        else $error("capture input misrouted");
    AST_IRQ0: assert property (p_route(IRQ0_IN, sh[7][0] ? PB_IN[4] : PA_IN[3]))
        else $error("irq zero misrouted");
    AST_EXT_RST: assert property (!$past(SRST) |-> EXT_RST_IN == ($past(RESET_PIN_CONTROL_RES_EN) ? $past(PB_IN[7]) : 1'b1))
        else $error("reset pin routing wrong");
    AST_ANALOG: assert property (!$past(SRST) && ($past(rb) || $past(fz)) |->
        AN_PATH_ON == ($past(rb) ? 8'h01 << $past(ADC_CH_SEL) : 8'h00))
        else $error("analog path wrong");
    AST_RB_READ: assert property (!$past(SRST) && $past(rb) |-> PB_READ == $past(PB_IN))
        else $error("readback port value wrong");
    AST_GPIO: assert property (!$past(SRST) && !$past(rb) && $past(fz) |-> PB_READ[3:0] == $past(gp_x))
        else $error("plain port read wrong");
    cover property (WR && ADDR == 4'h8 && WDATA == 8'hca ##2 READBACK_EN);
    cover property (sh[6][0] && ST_CAP_IN);
    cover property (RESET_PIN_CONTROL_RES_EN && !EXT_RST_IN);
endmodule
bind pfs_mux pfs_mux_sva pfs_mux_sva_inst (.MCLK(MCLK), .SRST(SRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RESET_PIN_CONTROL_RES_EN(RESET_PIN_CONTROL_RES_EN),
    .PA_IN(PA_IN), .PB_IN(PB_IN), .PC_IN(PC_IN), .PB_LATCH(PB_LATCH), .PB_DIR(PB_DIR),
    .PB_READ(PB_READ), .ADC_CH_SEL(ADC_CH_SEL), .ST_CAP_IN(ST_CAP_IN), .IRQ0_IN(IRQ0_IN),
    .EXT_RST_IN(EXT_RST_IN), .AN_PATH_ON(AN_PATH_ON), .READBACK_EN(READBACK_EN));

// File: verif/pfs_pins.sv
/* Far side model: package pin levels and peripheral outputs around the mux.
   Assumes the bench resolves pins that the mux drives from its enables. */
module pfs_pins (
    input logic clk,
    input logic freeze,
    output logic [7:0] pa,
    output logic [7:0] pb,
    output logic [7:0] pc,
    output logic [7:0] pd,
    output logic [13:0] per
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q = 8'h00;
    // Levels move every cycle unless frozen, so a stale or unrouted pin cannot match by luck
    always @(posedge clk) begin
        if (!freeze) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    assign pa = cnt_q ^ 8'h5a;
    assign pb = ~cnt_q;
    assign pc = {cnt_q[2:0], cnt_q[7:3]};
    assign pd = cnt_q + 8'h33;
    assign per = {cnt_q[5:0], ~cnt_q};
endmodule

// File: verif/testbench.sv
/* Self-checking bench for the pin function mux: register table, key, routing.
   Assumes the checker is bound and the far side model drives pins. */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [3:0] a; logic [7:0] w; logic [7:0] e;} pfs_row_t;
    pfs_row_t rows [10] = '{'{4'h0, 8'hff, 8'hff}, '{4'h1, 8'ha5, 8'ha5}, '{4'h2, 8'h5a, 8'h5a},
        '{4'h3, 8'hff, 8'h0f}, '{4'h4, 8'hff, 8'hf0}, '{4'h5, 8'hff, 8'h61},
        '{4'h6, 8'hff, 8'h01}, '{4'h7, 8'hff, 8'h03}, '{4'h8, 8'hca, 8'hca}, '{4'h9, 8'hff, 8'h00}};
    logic [7:0] keys [5] = '{8'hca, 8'hcb, 8'h4a, 8'hca, 8'h00};
    logic mclk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, reset_pin_control = 1'b0, frz = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, bl = 8'h3c, cl = 8'h96, dl = 8'h0f, bd = 8'hff, d;
    logic [2:0] ch = 3'h0;
    wire [7:0] rdata, pbo, pco, pdo, pbe, pce, pde, pbr, pcr, pdr, an, pa, xb, xc, xd, pb, pc, pd;
    wire [13:0] per;
    wire stc, pt0c, pt1c, cap, i0, i1, er, sck, sdi, serial_chip_select, vref, xtal, rben;
    int mismatches = 0;
    int samples_checked = 0;
    assign pb = (pbe & xb) | (~pbe & pbo);
    assign pc = (pce & xc) | (~pce & pco);
    assign pd = (pde & xd) | (~pde & pdo);
    pfs_pins pfs_pins_inst (.clk(mclk), .freeze(frz), .pa(pa), .pb(xb), .pc(xc), .pd(xd), .per(per));
    pfs_mux pfs_mux_inst (.MCLK(mclk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .RESET_PIN_CONTROL_RES_EN(reset_pin_control), .PA_IN(pa), .PB_IN(pb), .PC_IN(pc),
        .PD_IN(pd), .PB_LATCH(bl), .PC_LATCH(cl), .PD_LATCH(dl), .PB_DIR(bd), .PC_DIR(8'hff),
        .PD_DIR(8'hff), .PB_OUT(pbo), .PC_OUT(pco), .PD_OUT(pdo), .PB_OE_N(pbe), .PC_OE_N(pce),
        .PD_OE_N(pde), .PB_READ(pbr), .PC_READ(pcr), .PD_READ(pdr), .ST_OUT(per[0]),
        .PT0_OUT(per[1]), .PT1_OUT(per[2]), .SCK_OUT(per[3]), .SCK_OE(per[4]), .SDO_OUT(per[5]),
        .SDO_OE(per[6]), .SDA_OUT(per[7]), .SDA_OE(per[8]), .SCS_OUT(per[9]), .SCS_OE(per[10]),
        .SEG_OUT(per[13:11]), .ADC_CH_SEL(ch), .ST_CLK_IN(stc), .PT0_CLK_IN(pt0c),
        .PT1_CLK_IN(pt1c), .ST_CAP_IN(cap), .IRQ0_IN(i0), .IRQ1_IN(i1), .EXT_RST_IN(er),
        .SER_CLK_IN(sck), .SER_DATA_IN(sdi), .SER_CS_IN(serial_chip_select), .AN_PATH_ON(an),
        .VREF_PIN_ON(vref), .XTAL_ON(xtal), .READBACK_EN(rben));
    initial begin
        forever #20 mclk = ~mclk;
    end
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        chk8({7'h00, got}, {7'h00, exp}, what);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #120000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            rd_reg(rows[i].a, d);
            chk8(d, 8'h00, "reset value");
            wr_reg(rows[i].a, rows[i].w);
            rd_reg(rows[i].a, d);
            chk8(d, rows[i].e, "register readback");
        end
        $display("test registers done");
        foreach (keys[i]) begin
            wr_reg(4'h8, keys[i]);
            settle();
            chk1(rben, keys[i] === 8'hca, "readback enable");
        end
        $display("test key done");
        for (int i = 0; i < 8; i++) begin
            wr_reg(i[3:0], 8'h00);
        end
        // Shared digital inputs need only selection; input direction lets the far side drive the pins
        bd <= 8'hff;
        for (int s = 0; s < 2; s++) begin
            wr_reg(4'h5, s[0] ? 8'h61 : 8'h00);
            wr_reg(4'h6, {7'h00, s[0]});
            wr_reg(4'h7, {6'h00, s[0], s[0]});
            repeat (20) @(posedge mclk);
            frz <= 1'b1;
            settle();
            chk1(stc, s[0] ? pb[1] : pa[5], "std clock");
            chk1(pt0c, s[0] ? pb[2] : pa[4], "timer0 clock");
            chk1(pt1c, s[0] ? pb[3] : pd[0], "timer1 clock");
            chk1(cap, s[0] ? pc[0] : pb[6], "capture");
            chk1(i0, s[0] ? pb[4] : pa[3], "irq zero");
            chk1(i1, s[0] ? pb[5] : pa[1], "irq one");
            @(posedge mclk) frz <= 1'b0;
        end
        $display("test sources done");
        @(posedge mclk) frz <= 1'b1;
        reset_pin_control <= 1'b1;
        wr_reg(4'h0, 8'h02);
        wr_reg(4'h2, 8'h80);
        wr_reg(4'h3, 8'h0f);
        settle();
        chk1(er, pb[7], "reset pin");
        chk1(pbr[7], 1'b0, "reset pin read");
        chk1(pbr[0], 1'b0, "analog pin read");
        chk1(pcr[3], pc[3], "serial clock read");
        chk1(sck, pc[3], "serial clock in");
        chk1(xtal, 1'b1, "crystal");
        chk8(an, 8'h01, "analog path on");
        @(posedge mclk) ch <= 3'h3;
        settle();
        chk8(an, 8'h00, "analog path off");
        wr_reg(4'h8, 8'hca);
        settle();
        chk8(an, 8'h08, "forced path");
        chk8(pbr, pb, "readback port");
        // Alternate drives: timer outputs, segments, serial lines, reference pin
        wr_reg(4'h8, 8'h00);
        wr_reg(4'h0, 8'h03);
        wr_reg(4'h1, 8'h0a);
        wr_reg(4'h2, 8'heb);
        wr_reg(4'h4, 8'hf0);
        settle();
        d = {~per[0], ~per[1], 2'b00, ~per[2], per[2], 2'b00};
        chk8({pbo[5:4], pbe[5:4], pdo[3:2], pde[3:2]}, d, "timer drive");
        d = {per[13], per[5], per[7], per[9], 1'b0, ~per[6], ~per[8], ~per[10]};
        chk8({pco[3:0], pce[3:0]}, d, "port c drive");
        d = {pc[1], pc[0], 1'b1, 1'b0, pc[2], pc[1], 2'b00};
        chk8({sdi, serial_chip_select, vref, pcr[3:1], pbr[5:4]}, d, "serial and reads");
        $display("test functions done");
        @(posedge mclk);
        srst <= 1'b1;
        reset_pin_control <= 1'b0;
        bd <= 8'h0f;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd_reg(4'h8, d);
        chk8(d, 8'h00, "key after reset");
        chk1(rben, 1'b0, "enable after reset");
        settle();
        chk8(pbr, {bl[7:4], pb[3:0]}, "plain port read");
        $display("test reset done");
        report_and_stop();
    end
endmodule
